// >>> pfle_evaluator.sv
// Purpose: Checks and repeatedly evaluates a postfix Boolean parameter list
// Assumes: Operands and timer outputs are synchronous to sys_clk
// Notes: A failed check halts evaluation until the next edit
`timescale 1ns/10ps
`default_nettype none
module pfle_evaluator (
  input wire logic sys_clk, // Clock, 250 MHz
  input wire logic srst, // Synchronous reset, high
  input wire logic [255:0] srcOperand, // Relay operand states
  input wire logic [31:0] timerOut, // Timer outputs
  input wire logic editValid, // Edit request
  input wire logic [1:0] editCmd, // Write, insert or delete
  input wire logic [9:0] editPos, // Entry number, 1 to 512
  input wire logic [15:0] editData, // Entry code
  output logic editReady, // Edit may be taken
  output logic [63:0] softOut, // Soft outputs
  output logic [31:0] timerStart, // Timer start inputs
  output logic passDone, // Pass finished pulse
  output logic compileError // List check failed
);
  // ==========================================================
  // State
  typedef enum logic [1:0] {
    ST_WAIT = 2'b00, ST_COMPILE = 2'b01, ST_EVAL = 2'b10, ST_HALT = 2'b11
  } pfle_st_t;
  typedef struct packed {
    pfle_st_t st;
    logic [8:0] pc;
    logic [5:0] cDepth;
    logic cErr;
    logic [pfle_pkg::NUM_TIMERS-1:0] tmSeen;
    logic [pfle_pkg::NUM_SOFTOUT-1:0] voSeen;
    logic [pfle_pkg::NUM_LATCH-1:0] latch;
    logic [pfle_pkg::NUM_ONESHOT-1:0] osPrev;
    logic [pfle_pkg::NUM_SOFTOUT-1:0] softOut;
    logic [pfle_pkg::NUM_TIMERS-1:0] tmStart;
    logic passDone;
    logic edReady;
    logic cmpErr;
  } pfle_core_t;
  pfle_core_t r, n;
  localparam logic [8:0] LAST = 9'h1FF;
  localparam logic [9:0] POS_MAX = 10'h200;

  pfle_core_if core ();

  // ==========================================================
  // Submodules
  pfle_param_store u_store (
    .sys_clk(sys_clk),
    .srst(srst),
    .bus(core)
  );
  pfle_result_stack u_stack (
    .sys_clk(sys_clk),
    .srst(srst),
    .bus(core)
  );

  // ==========================================================
  // Input counts each entry kind consumes from the stack
  function automatic logic [4:0] popsOf(input pfle_pkg::pfle_kind_t k,
                                        input logic [4:0] cnt);
    logic [4:0] p;
    p = 5'h00;
    unique case (k)
      pfle_pkg::K_NOT, pfle_pkg::K_POS, pfle_pkg::K_NEG, pfle_pkg::K_DUAL,
      pfle_pkg::K_TIMER, pfle_pkg::K_ASSIGN: p = 5'h01;
      pfle_pkg::K_XOR, pfle_pkg::K_LATCH: p = 5'h02;
      pfle_pkg::K_OR, pfle_pkg::K_AND, pfle_pkg::K_NOR, pfle_pkg::K_NAND: p = cnt;
      default: p = 5'h00;
    endcase
    return p;
  endfunction : popsOf

  // ==========================================================
  // Decode of the current entry
  pfle_pkg::pfle_entry_t ent;
  logic [4:0] cnt;
  logic [4:0] pops;
  logic [4:0] i5;
  logic [5:0] i6;
  logic [15:0] win;
  logic [15:0] mask;
  logic isGate;
  logic isEnd;
  logic editOk;

  always_comb begin
    ent = pfle_pkg::pfle_entry_t'(core.rdData);
    cnt = ent.arg[4:0];
    i5 = ent.arg[4:0];
    i6 = ent.arg[5:0];
    // Newest results, top of stack in lane 0
    win = core.stkTop;
    // Inputs this entry takes from the stack
    pops = popsOf(ent.kind, cnt);
    // Lanes of the window that belong to a counted gate
    mask = (cnt > 5'h10) ? 16'hFFFF : 16'hFFFF >> (5'h10 - cnt);
    isGate = ent.kind inside {pfle_pkg::K_OR, pfle_pkg::K_AND,
                              pfle_pkg::K_NOR, pfle_pkg::K_NAND};
    isEnd = ent.kind == pfle_pkg::K_END;
    // Positions outside 1 to 512 and the spare command are dropped silently
    editOk = editValid && r.edReady && editPos != 10'h000 && editPos <= POS_MAX
             && editCmd != 2'b11;
  end

  // ==========================================================
  // Sequencer: edit hand-off, list check, evaluation passes
  logic res;
  logic push;
  logic [5:0] depthAfter;

  always_comb begin
    n = r;
    n.passDone = 1'b0;
    res = 1'b0;
    push = 1'b0;
    depthAfter = 6'h00;
    core.rdAddr = r.pc;
    core.edStart = 1'b0;
    core.edCmd = editCmd;
    core.edPos = 9'(editPos - 10'h001);
    core.edData = editData;
    core.stkClr = 1'b0;
    core.stkPop = 5'h00;
    core.stkPush = 1'b0;
    core.stkBit = 1'b0;
    unique case (r.st)
      // Wait for the store, then restart the check from entry 1
      ST_WAIT: begin
        // Recompile once the store has finished shifting
        if (!core.edBusy) begin
          n.st = ST_COMPILE;
          n.pc = 9'h000;
          n.cDepth = 6'h00;
          n.cErr = 1'b0;
          n.tmSeen = '0;
          n.voSeen = '0;
          n.latch = '0;
          core.stkClr = 1'b1;
        end
      end
      // One entry per clock; errors gather until the list ends
      ST_COMPILE: begin
        // Operator needs more inputs than the equation has pushed
        if (r.cDepth < {1'b0, pops}) begin
          n.cErr = 1'b1;
        end
        // Gate input count outside the allowed range
        if (isGate && (cnt < 5'(pfle_pkg::GATE_MIN_IN) ||
                       cnt > 5'(pfle_pkg::GATE_MAX_IN))) begin
          n.cErr = 1'b1;
        end
        // A timer or soft output number may be claimed by one entry only
        if (ent.kind == pfle_pkg::K_TIMER) begin
          if (r.tmSeen[i5]) begin
            n.cErr = 1'b1;
          end
          n.tmSeen[i5] = 1'b1;
        end
        if (ent.kind == pfle_pkg::K_ASSIGN) begin
          if (r.voSeen[i6]) begin
            n.cErr = 1'b1;
          end
          n.voSeen[i6] = 1'b1;
        end
        // Track depth: pops, one result, and an assignment empties it
        depthAfter = r.cDepth - {1'b0, pops};
        if (ent.kind != pfle_pkg::K_ASSIGN && !isEnd) begin
          depthAfter = depthAfter + 6'h01;
        end
        // Deeper than the result stack can hold
        if (depthAfter > 6'(pfle_pkg::STACK_DEPTH)) begin
          n.cErr = 1'b1;
        end
        n.cDepth = (ent.kind == pfle_pkg::K_ASSIGN) ? 6'h00 : depthAfter;
        // Check ends at the first terminator or at the last entry
        if (isEnd || r.pc == LAST) begin
          n.pc = 9'h000;
          n.cmpErr = n.cErr;
          n.edReady = 1'b1;
          n.st = n.cErr ? ST_HALT : ST_EVAL;
          if (n.cErr) begin
            n.softOut = '0;
            n.tmStart = '0;
          end
        end else begin
          n.pc = r.pc + 9'h001;
        end
      end
      // One entry per clock; an edit takes priority over evaluation
      ST_EVAL: begin
        if (editOk) begin
          // An edit abandons the pass in progress
          core.edStart = 1'b1;
          n.edReady = 1'b0;
          n.st = ST_WAIT;
        end else begin
          unique case (ent.kind)
            // Terminator pushes nothing; the pass ends below
            pfle_pkg::K_END: res = 1'b0;
            // Operand kinds push a level: relay source, soft output, timer
            pfle_pkg::K_OPND: begin
              res = srcOperand[ent.arg[7:0]];
              push = 1'b1;
            end
            pfle_pkg::K_VOREF: begin
              res = r.softOut[i6];
              push = 1'b1;
            end
            pfle_pkg::K_TMREF: begin
              res = timerOut[i5];
              push = 1'b1;
            end
            // Gates work on the newest lanes of the window
            pfle_pkg::K_NOT: begin
              res = ~win[0];
              push = 1'b1;
            end
            pfle_pkg::K_OR: begin
              res = |(win & mask);
              push = 1'b1;
            end
            pfle_pkg::K_AND: begin
              res = &(win | ~mask);
              push = 1'b1;
            end
            pfle_pkg::K_NOR: begin
              res = ~|(win & mask);
              push = 1'b1;
            end
            pfle_pkg::K_NAND: begin
              res = ~&(win | ~mask);
              push = 1'b1;
            end
            pfle_pkg::K_XOR: begin
              res = win[0] ^ win[1];
              push = 1'b1;
            end
            // Latch memory survives between passes until a recompile
            pfle_pkg::K_LATCH: begin
              // Reset on top of stack, set beneath it
              res = (win[1] | r.latch[i5]) & ~win[0];
              n.latch[i5] = res;
              push = 1'b1;
            end
            // One-shots compare with their input in the previous pass
            pfle_pkg::K_POS: begin
              res = win[0] & ~r.osPrev[i5];
              n.osPrev[i5] = win[0];
              push = 1'b1;
            end
            pfle_pkg::K_NEG: begin
              res = ~win[0] & r.osPrev[i5];
              n.osPrev[i5] = win[0];
              push = 1'b1;
            end
            pfle_pkg::K_DUAL: begin
              res = win[0] ^ r.osPrev[i5];
              n.osPrev[i5] = win[0];
              push = 1'b1;
            end
            // Timer start follows its input; the pushed result is its output
            pfle_pkg::K_TIMER: begin
              n.tmStart[i5] = win[0];
              res = timerOut[i5];
              push = 1'b1;
            end
            // Assignment stores the newest result; the stack is emptied below
            pfle_pkg::K_ASSIGN: begin
              n.softOut[i6] = win[0];
            end
          endcase
          // Stack update for the entry just decoded
          core.stkPop = pops;
          core.stkPush = push;
          core.stkBit = res;
          core.stkClr = ent.kind == pfle_pkg::K_ASSIGN;
          // Restart straight away; a pass is at most PASS_WORST_CYC clocks
          if (isEnd || r.pc == LAST) begin
            core.stkClr = 1'b1;
            n.pc = 9'h000;
            n.passDone = 1'b1;
          end else begin
            n.pc = r.pc + 9'h001;
          end
        end
      end
      ST_HALT: begin
        // Only an edit leaves the halted state; outputs stay cleared
        if (editOk) begin
          core.edStart = 1'b1;
          n.edReady = 1'b0;
          n.st = ST_WAIT;
        end
      end
    endcase
  end

  // ==========================================================
  // State register; reset clears latches and starts a check of the empty list
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      r <= '0;
      r.st <= ST_COMPILE;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from the state register
  assign editReady = r.edReady;
  assign softOut = r.softOut;
  assign timerStart = r.tmStart;
  assign passDone = r.passDone;
  assign compileError = r.cmpErr;
endmodule : pfle_evaluator
`default_nettype wire

// >>> pfle_pkg.sv
// Purpose: Shared constants and types of the postfix logic evaluator
// Assumes: 16-bit list entries, kind in the top nibble, argument below
// Notes: Entry code zero is the list terminator, so a cleared list is all ends
package pfle_pkg;
  // ==========================================================
  // Sizes
  localparam int LIST_LEN = 512;
  localparam int NUM_TIMERS = 32;
  localparam int NUM_SOFTOUT = 64;
  localparam int NUM_ONESHOT = 32;
  localparam int NUM_LATCH = 32;
  localparam int NUM_OPERANDS = 256;
  localparam int STACK_DEPTH = 32;
  localparam int GATE_MIN_IN = 2;
  localparam int GATE_MAX_IN = 16;
  localparam int WIN_W = 16;
  localparam int ENTRY_W = 16;
  // ==========================================================
  // Timing
  localparam int CLK_HZ = 250000000;
  localparam int LINE_HZ = 60;
  localparam int PASSES_PER_LINE = 4;
  // Worst pass bound: every entry once plus one; the restart itself takes no extra cycle
  localparam int PASS_WORST_CYC = LIST_LEN + 1;
  localparam int PASS_BUDGET_CYC = CLK_HZ / (LINE_HZ * PASSES_PER_LINE);
  // ==========================================================
  // Entry layout
  localparam int KIND_POS = 12;
  localparam logic [ENTRY_W-1:0] ENTRY_RESET = 16'h0000;
  typedef enum logic [3:0] {
    K_END = 4'b0000, K_OPND = 4'b0001, K_VOREF = 4'b0010, K_TMREF = 4'b0011,
    K_NOT = 4'b0100, K_OR = 4'b0101, K_AND = 4'b0110, K_NOR = 4'b0111,
    K_NAND = 4'b1000, K_XOR = 4'b1001, K_LATCH = 4'b1010, K_POS = 4'b1011,
    K_NEG = 4'b1100, K_DUAL = 4'b1101, K_TIMER = 4'b1110, K_ASSIGN = 4'b1111
  } pfle_kind_t;
  typedef struct packed {
    pfle_kind_t kind;
    logic [KIND_POS-1:0] arg;
  } pfle_entry_t;
  // ==========================================================
  // Editor commands
  typedef enum logic [1:0] {
    ED_WRITE = 2'b00, ED_INSERT = 2'b01, ED_DELETE = 2'b10
  } pfle_edit_t;
endpackage : pfle_pkg

// >>> pfle_core_if.sv
// Purpose: Links the evaluator core to its list store and result stack
// Assumes: One clock domain
// Notes: Stack window is registered inside its owner; read data is an unregistered read at rdAddr
`timescale 1ns/10ps
`default_nettype none
interface pfle_core_if;
  // ==========================================================
  // List store side
  logic [8:0] rdAddr;
  logic [15:0] rdData;
  logic edStart;
  logic [1:0] edCmd;
  logic [8:0] edPos;
  logic [15:0] edData;
  logic edBusy;
  // ==========================================================
  // Result stack side
  logic stkClr;
  logic [4:0] stkPop;
  logic stkPush;
  logic stkBit;
  logic [15:0] stkTop;
  logic [5:0] stkDepth;
  modport core (output rdAddr, edStart, edCmd, edPos, edData, stkClr, stkPop,
                stkPush, stkBit, input rdData, edBusy, stkTop, stkDepth);
  modport store (input rdAddr, edStart, edCmd, edPos, edData,
                 output rdData, edBusy);
  modport stack (input stkClr, stkPop, stkPush, stkBit, output stkTop, stkDepth);
endinterface : pfle_core_if
`default_nettype wire

// >>> pfle_param_store.sv
// Purpose: Holds the parameter list and performs write, insert and delete
// Assumes: Positions arrive zero based and already range checked
// Notes: Shifts move one entry per clock, so long edits take many cycles
`timescale 1ns/10ps
`default_nettype none
module pfle_param_store (
  input wire logic sys_clk, // Clock
  input wire logic srst, // Synchronous reset
  pfle_core_if.store bus // Core link
);
  typedef enum logic [1:0] {S_IDLE = 2'b00, S_UP = 2'b01, S_DN = 2'b10} pfle_sst_t;
  typedef struct packed {
    logic [pfle_pkg::LIST_LEN-1:0][pfle_pkg::ENTRY_W-1:0] mem;
    pfle_sst_t st;
    logic [8:0] idx;
    logic [8:0] pos;
    logic [15:0] data;
    logic busy;
  } pfle_store_t;
  pfle_store_t r, n;
  localparam logic [8:0] LAST = 9'h1FF;

  // ==========================================================
  // Read port and busy flag
  assign bus.rdData = r.mem[bus.rdAddr];
  assign bus.edBusy = r.busy;

  // Edit engine
  always_comb begin
    n = r;
    unique case (r.st)
      S_IDLE: begin
        if (bus.edStart) begin
          n.pos = bus.edPos;
          n.data = bus.edData;
          if (bus.edCmd == pfle_pkg::ED_WRITE) begin
            n.mem[bus.edPos] = bus.edData;
          end else if (bus.edPos == LAST) begin
            // Insert or delete at the tail touches one entry only
            n.mem[LAST] = (bus.edCmd == pfle_pkg::ED_INSERT) ? bus.edData
                                                            : pfle_pkg::ENTRY_RESET;
          end else if (bus.edCmd == pfle_pkg::ED_INSERT) begin
            n.st = S_UP;
            n.idx = LAST;
            n.busy = 1'b1;
          end else begin
            n.st = S_DN;
            n.idx = bus.edPos;
            n.busy = 1'b1;
          end
        end
      end
      S_UP: begin
        if (r.idx == r.pos) begin
          n.mem[r.idx] = r.data;
          n.st = S_IDLE;
          n.busy = 1'b0;
        end else begin
          n.mem[r.idx] = r.mem[r.idx - 9'h001];
          n.idx = r.idx - 9'h001;
        end
      end
      S_DN: begin
        if (r.idx == LAST) begin
          n.mem[LAST] = pfle_pkg::ENTRY_RESET;
          n.st = S_IDLE;
          n.busy = 1'b0;
        end else begin
          n.mem[r.idx] = r.mem[r.idx + 9'h001];
          n.idx = r.idx + 9'h001;
        end
      end
      default: begin
        n.st = S_IDLE;
        n.busy = 1'b0;
      end
    endcase
  end

  // State register, list cleared to terminators
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule : pfle_param_store
`default_nettype wire

// >>> pfle_result_stack.sv
// Purpose: One-bit result stack with multi-pop and single push per clock
// Assumes: Caller never pops more than the depth it holds
// Notes: Top of stack is bit 0 of the window
`timescale 1ns/10ps
`default_nettype none
module pfle_result_stack (
  input wire logic sys_clk, // Clock
  input wire logic srst, // Synchronous reset
  pfle_core_if.stack bus // Core link
);
  typedef struct packed {
    logic [pfle_pkg::STACK_DEPTH-1:0] bits;
    logic [5:0] depth;
  } pfle_stk_t;
  pfle_stk_t r, n;

  // ==========================================================
  // Window onto the newest results
  assign bus.stkTop = r.bits[15:0];
  assign bus.stkDepth = r.depth;

  // Pop first, then push the operator result
  always_comb begin
    n = r;
    if (bus.stkClr) begin
      n = '0;
    end else begin
      n.bits = r.bits >> bus.stkPop;
      n.depth = r.depth - {1'b0, bus.stkPop};
      if (bus.stkPush) begin
        n.bits = {n.bits[30:0], bus.stkBit};
        n.depth = n.depth + 6'h01;
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule : pfle_result_stack
`default_nettype wire

// >>> pfle_timer_model.sv
// Purpose: Behavioural bank of 32 pickup timers on the evaluator's far side
// Assumes: Pickup delay in clocks, instant dropout
// Notes: Delay is short so bench passes stay brief
`timescale 1ns/10ps
`default_nettype none
module pfle_timer_model #(
  parameter int PICKUP = 3
) (
  input wire logic sys_clk, // Clock
  input wire logic srst, // Synchronous reset
  input wire logic [31:0] timerStart, // Start inputs
  output logic [31:0] timerOut // Timer outputs
);
  // ==========================================================
  // Delay line
  logic [31:0] hist_r [PICKUP];
  // Output rises only after start held for the full pickup
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < PICKUP; i++) begin
      hist_r[i] <= srst ? 32'h0 : ((i == 0) ? timerStart : hist_r[i-1] & timerStart);
    end
  end
  assign timerOut = hist_r[PICKUP-1] & timerStart;
endmodule : pfle_timer_model
`default_nettype wire

// >>> pfle_evaluator_assertions.sv
// Purpose: Port level checks of the postfix evaluator
// Assumes: Single clock, srst synchronous high
// Notes: Bound from the bench top file
`timescale 1ns/10ps
`default_nettype none
module pfle_evaluator_assertions (
  input wire logic sys_clk, // Clock
  input wire logic srst, // Reset
  input wire logic [255:0] srcOperand, // Operands
  input wire logic [31:0] timerOut, // Timer outputs
  input wire logic editValid, // Edit request
  input wire logic [1:0] editCmd, // Edit command
  input wire logic [9:0] editPos, // Entry number
  input wire logic [15:0] editData, // Entry code
  input wire logic editReady, // Edit may be taken
  input wire logic [63:0] softOut, // Soft outputs
  input wire logic [31:0] timerStart, // Timer starts
  input wire logic passDone, // Pass pulse
  input wire logic compileError // Check failed
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // ==========================================================
  // Helpers
  logic legal;
  logic [10:0] lowCnt_r;
  logic [9:0] passGap_r;
  assign legal = editValid && editCmd != 2'h3 && editPos != 10'h000 && editPos <= 10'h200;
  // Counts cycles with edit port busy
  always_ff @(posedge sys_clk) begin
    if (srst || editReady) lowCnt_r <= 11'h000;
    else if (lowCnt_r != 11'h7FF) lowCnt_r <= lowCnt_r + 11'h001;
  end
  // Counts evaluation cycles since the last pass ended
  always_ff @(posedge sys_clk) begin
    if (srst || !editReady || compileError || passDone) passGap_r <= 10'h000;
    else if (passGap_r != 10'h3FF) passGap_r <= passGap_r + 10'h001;
  end
  // ==========================================================
  // Properties
  a_reset_clears: assert property (disable iff (1'b0) srst |=>
    !editReady && !passDone && !compileError && softOut == 64'h0 && timerStart == 32'h0)
    else $error("outputs not cleared by reset");
  a_ready_after_rst: assert property ($fell(srst) |-> ##[1:4] editReady)
    else $error("edit port not ready after reset");
  a_edit_taken: assert property (editReady && legal |=> !editReady)
    else $error("legal edit not taken");
  a_edit_ignored: assert property (editReady && !legal |=> editReady)
    else $error("edit port dropped without a legal edit");
  a_ready_bounded: assert property (lowCnt_r < 11'h4B0)
    else $error("recompile took too long");
  a_pass_pulse: assert property (passDone && $past(passDone) |->
    $stable(softOut) && $stable(timerStart)) else $error("back to back pass changed outputs");
  a_pass_in_eval: assert property (passDone |-> editReady && !compileError)
    else $error("pass ended outside evaluation");
  a_pass_bounded: assert property (passGap_r < 10'(pfle_pkg::PASS_WORST_CYC))
    else $error("evaluation pass too long");
  a_halt_quiet: assert property (compileError && $past(compileError) |->
    softOut == 64'h0 && timerStart == 32'h0) else $error("outputs active while halted");
  a_no_pass_edit: assert property (!editReady && !$past(editReady) |-> !passDone)
    else $error("pass finished during recompile");
endmodule : pfle_evaluator_assertions
`default_nettype wire

// >>> pfle_evaluator_test.sv
// Purpose: Self-checking bench of the postfix evaluator
// Assumes: Inputs driven at falling edge
// Notes: List 1 op0, 2 op1, 3 operator under test, 4 assign soft output 0
`timescale 1ns/10ps
`default_nettype none
`define CHECK(got, exp) begin checked++; if ((got) !== (exp)) begin errCount++; \
  $display("[FAIL] %0t value mismatch", $time); end end
module pfle_evaluator_test;
  typedef struct packed {logic [3:0] kind; logic [11:0] arg; logic a; logic b; logic exp;} pfle_row_t;
  logic sys_clk = 1'b0, srst = 1'b1, editValid = 1'b0, editReady, passDone, compileError;
  logic [255:0] srcOperand = 256'h0;
  logic [31:0] timerOut, timerStart;
  logic [1:0] editCmd = 2'h0;
  logic [9:0] editPos = 10'h000;
  logic [15:0] editData = 16'h0000;
  logic [63:0] softOut;
  logic [3:0] hits;
  int errCount = 0, checked = 0;
  // Timer and soft output reference rows lean on the row before them
  pfle_row_t rows [18] = '{
    '{pfle_pkg::K_OR, 12'h002, 0, 0, 0}, '{pfle_pkg::K_OR, 12'h002, 0, 1, 1},
    '{pfle_pkg::K_AND, 12'h002, 1, 1, 1}, '{pfle_pkg::K_AND, 12'h002, 1, 0, 0},
    '{pfle_pkg::K_NOR, 12'h002, 0, 0, 1}, '{pfle_pkg::K_NOR, 12'h002, 1, 0, 0},
    '{pfle_pkg::K_NAND, 12'h002, 1, 1, 0}, '{pfle_pkg::K_NAND, 12'h002, 0, 1, 1},
    '{pfle_pkg::K_XOR, 12'h000, 1, 1, 0}, '{pfle_pkg::K_XOR, 12'h000, 1, 0, 1},
    '{pfle_pkg::K_NOT, 12'h000, 1, 0, 1}, '{pfle_pkg::K_NOT, 12'h000, 0, 1, 0},
    '{pfle_pkg::K_LATCH, 12'h000, 1, 0, 1}, '{pfle_pkg::K_LATCH, 12'h000, 1, 1, 0},
    '{pfle_pkg::K_TIMER, 12'h000, 1, 0, 0}, '{pfle_pkg::K_TIMER, 12'h000, 0, 1, 1},
    '{pfle_pkg::K_TMREF, 12'h000, 0, 0, 1}, '{pfle_pkg::K_VOREF, 12'h000, 0, 0, 1}};
  // ==========================================================
  // Clock, design and far side
  always #2 sys_clk = ~sys_clk;
  pfle_evaluator u_pfle_evaluator (.sys_clk(sys_clk), .srst(srst), .srcOperand(srcOperand),
    .timerOut(timerOut), .editValid(editValid), .editCmd(editCmd), .editPos(editPos),
    .editData(editData), .editReady(editReady), .softOut(softOut), .timerStart(timerStart),
    .passDone(passDone), .compileError(compileError));
  pfle_timer_model u_pfle_timer_model (.sys_clk(sys_clk), .srst(srst),
    .timerStart(timerStart), .timerOut(timerOut));
  // ==========================================================
  // Tasks
  task automatic testDone();
    $display("Comparisons %0d, mismatches %0d", checked, errCount);
    if (errCount == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : testDone
  task automatic waitReady();
    int i;
    for (i = 0; i < 2000; i++) begin
      if (editReady === 1'b1) break;
      @(negedge sys_clk);
    end
    if (i == 2000) begin errCount++; testDone(); end
  endtask : waitReady
  task automatic edit(input logic [1:0] cmd, input logic [9:0] pos, input logic [15:0] data);
    editCmd = cmd;
    editPos = pos;
    editData = data;
    editValid = 1'b1;
    @(negedge sys_clk);
    editValid = 1'b0;
    @(negedge sys_clk);
    waitReady();
  endtask : edit
  task automatic passes(input int n, input logic a, input logic b);
    int i;
    srcOperand[1:0] = {b, a};
    repeat (n) begin
      for (i = 0; i < 600; i++) begin
        @(negedge sys_clk);
        if (passDone === 1'b1) break;
      end
      if (i == 600) begin errCount++; testDone(); end
    end
  endtask : passes
  // ==========================================================
  // Main sequence
  initial begin
    repeat (12) @(negedge sys_clk);
    srst = 1'b0;
    @(negedge sys_clk);
    waitReady();
    `CHECK(softOut, 64'h0)
    `CHECK(compileError, 1'b0)
    edit(pfle_pkg::ED_WRITE, 10'h001, 16'h1000);
    edit(pfle_pkg::ED_WRITE, 10'h002, 16'h1001);
    edit(pfle_pkg::ED_WRITE, 10'h004, 16'hF000);
    // Table of gates, latch, timer and the timer and soft output references
    foreach (rows[r]) begin
      srcOperand[1:0] = {rows[r].b, rows[r].a};
      edit(pfle_pkg::ED_WRITE, 10'h003, {rows[r].kind, rows[r].arg});
      passes(4, rows[r].a, rows[r].b);
      `CHECK(softOut[0], rows[r].exp)
      if (rows[r].kind == pfle_pkg::K_TIMER) `CHECK(timerStart[0], rows[r].b)
    end
    // Latch holds after set drops, reset wins
    edit(pfle_pkg::ED_WRITE, 10'h003, 16'hA000);
    passes(4, 1'b1, 1'b0);
    passes(4, 1'b0, 1'b0);
    `CHECK(softOut[0], 1'b1)
    passes(4, 1'b1, 1'b1);
    `CHECK(softOut[0], 1'b0)
    // One-shots: rising, falling, both
    for (int k = 0; k < 3; k++) begin
      edit(pfle_pkg::ED_WRITE, 10'h003, {4'hB + 4'(k), 12'h000});
      passes(4, 1'b0, 1'b0);
      hits = 4'h0;
      for (int p = 0; p < 8; p++) begin
        passes(1, 1'b0, p < 4);
        if (softOut[0] === 1'b1) hits++;
      end
      `CHECK(hits, (k == 2) ? 4'h2 : 4'h1)
    end
    // Entries past the terminator are skipped, then delete and insert shift
    edit(pfle_pkg::ED_WRITE, 10'h006, 16'h1000);
    edit(pfle_pkg::ED_WRITE, 10'h007, 16'hF001);
    passes(4, 1'b1, 1'b0);
    `CHECK(softOut[1], 1'b0)
    edit(pfle_pkg::ED_DELETE, 10'h005, 16'h0000);
    passes(4, 1'b1, 1'b0);
    `CHECK(softOut[1], 1'b1)
    edit(pfle_pkg::ED_INSERT, 10'h006, 16'h4000);
    passes(4, 1'b1, 1'b0);
    `CHECK(softOut[1], 1'b0)
    // Refused command leaves the port ready
    editCmd = 2'h3;
    editPos = 10'h001;
    editValid = 1'b1;
    repeat (2) @(negedge sys_clk);
    editValid = 1'b0;
    @(negedge sys_clk);
    `CHECK(editReady, 1'b1)
    // Second assignment of soft output 0 halts evaluation
    edit(pfle_pkg::ED_WRITE, 10'h008, 16'h1000);
    edit(pfle_pkg::ED_WRITE, 10'h009, 16'hF000);
    repeat (4) @(negedge sys_clk);
    `CHECK(compileError, 1'b1)
    `CHECK(softOut, 64'h0)
    edit(pfle_pkg::ED_WRITE, 10'h009, 16'h0000);
    `CHECK(compileError, 1'b0)
    testDone();
  end
endmodule : pfle_evaluator_test
bind pfle_evaluator pfle_evaluator_assertions u_chk (.sys_clk(sys_clk), .srst(srst),
  .srcOperand(srcOperand), .timerOut(timerOut), .editValid(editValid), .editCmd(editCmd),
  .editPos(editPos), .editData(editData), .editReady(editReady), .softOut(softOut),
  .timerStart(timerStart), .passDone(passDone), .compileError(compileError));
`default_nettype wire
